// ==== design/dtmc_channel.sv ====
`timescale 1ns/10ps
`default_nettype none

module dtmc_channel #(
	parameter int WIDTH = dtmc_pkg::TIMER_W
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [1:0] i_mode,
	input wire logic i_stop,
	input wire logic i_edge_sel,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_load_value,
	input wire logic i_pin,
	output logic [WIDTH-1:0] o_count,
	output logic o_pin,
	output logic o_pin_oe,
	output logic o_pin_event,
	output logic o_underflow
);
	import dtmc_pkg::*;

	logic pin_prev;
	logic pin_rise;
	logic pin_fall;
	logic step;
	logic [WIDTH-1:0] reload;
	logic pulse_phase;

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= i_pin;
		end
	end

	assign pin_rise = i_pin & ~pin_prev;
	assign pin_fall = ~i_pin & pin_prev;

	// The request edge follows the edge bit alone, whatever the mode.
	assign o_pin_event = i_edge_sel ? pin_rise : pin_fall; // R05 R06 R07

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		step = 1'b0;
		if (!i_stop) begin // R03 R04
			case (i_mode)
				MODE_TIMER: step = 1'b1; // R06
				MODE_PULSE: step = 1'b1;
				MODE_EVENT: step = i_edge_sel ? pin_fall : pin_rise; // R09
				MODE_WIDTH: step = (i_pin == ~i_edge_sel); // R10
				default: step = 1'b0;
			endcase
		end
	end

	assign o_underflow = step && (o_count == '0) && !i_load;

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_count <= '0;
			reload <= '0;
		end else if (i_load) begin
			o_count <= i_load_value;
			reload <= i_load_value;
		end else if (step) begin
			o_count <= (o_count == '0) ? reload : o_count - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// The phase restarts outside pulse mode and on a load. The level is read
	// against the live edge bit, so that a write that selects pulse mode and the
	// edge bit together already shows the selected start level in its first cycle.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pulse_phase <= 1'b0;
		end else if (i_mode != MODE_PULSE || i_load) begin
			pulse_phase <= 1'b0;
		end else if (o_underflow) begin
			pulse_phase <= ~pulse_phase;
		end
	end

	assign o_pin = ~(pulse_phase ^ i_edge_sel); // R08
	assign o_pin_oe = (i_mode == MODE_PULSE);

endmodule

`default_nettype wire

// ==== design/dtmc_pkg.sv ====
package dtmc_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int CHANNELS = 2;
	localparam int TIMER_W = 8;

	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h23;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_X = 8'h24;
	localparam logic [ADDR_W-1:0] ADDR_TIMER_Y = 8'h25;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h30;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h31;

	// Mode register layout: one nibble per timer, timer X in the low nibble.
	localparam int FIELD_STRIDE = 4;
	localparam int MODE_LSB = 0;
	localparam int EDGE_BIT = 2;
	localparam int STOP_BIT = 3;

	localparam logic [1:0] MODE_TIMER = 2'h0;
	localparam logic [1:0] MODE_PULSE = 2'h1;
	localparam logic [1:0] MODE_EVENT = 2'h2;
	localparam logic [1:0] MODE_WIDTH = 2'h3;

	// Interrupt status and mask layout.
	localparam int IRQ_BITS = 4;
	localparam int IRQ_PIN_LSB = 0;
	localparam int IRQ_UNDERFLOW_LSB = 2;

	localparam logic [DATA_W-1:0] MODE_RESET = 8'h00;
	localparam logic [IRQ_BITS-1:0] IRQ_STATUS_RESET = 4'h0;
	localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 4'h0;
	localparam logic [DATA_W-1:0] RDATA_RESET = 8'h00;

endpackage

// ==== design/dtmc_top.sv ====
// Behaviour
// R01 - Bits 1:0 select timer X mode.
// R02 - Bits 5:4 select timer Y mode.
// R03 - Bit 3 set halts timer X.
// R04 - Bit 7 set halts timer Y.
// R05 - Bits 2, 6 are per-timer edge selects.
// R06 - Timer mode: edge bit only picks interrupt edge.
// R07 - Pin request on falling edge, rising if set.
// R08 - Pulse starts high, or low if set.
// R09 - Event mode counts rising, or falling if set.
// R10 - Width mode measures high, or low if set.
// R11 - Mode register resets to zero.
`timescale 1ns/10ps
`default_nettype none

module dtmc_top #(
	parameter int TIMER_WIDTH = dtmc_pkg::TIMER_W
) (
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic [dtmc_pkg::ADDR_W-1:0] i_addr,
	input wire logic [dtmc_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [dtmc_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_counter_pin_x,
	output logic o_counter_pin_x,
	output logic o_counter_pin_x_oe,
	input wire logic i_counter_pin_y,
	output logic o_counter_pin_y,
	output logic o_counter_pin_y_oe,
	output logic o_irq
);
	import dtmc_pkg::*;

	logic [DATA_W-1:0] timer_pair_mode_reg;
	logic [IRQ_BITS-1:0] irq_status;
	logic [IRQ_BITS-1:0] irq_mask;
	logic [IRQ_BITS-1:0] irq_events;
	logic [IRQ_BITS-1:0] irq_clear;
	logic [DATA_W-1:0] next_rdata;

	logic [1:0] ch_mode [CHANNELS];
	logic ch_stop [CHANNELS];
	logic ch_edge [CHANNELS];
	logic ch_load [CHANNELS];
	logic ch_pin_in [CHANNELS];
	logic [TIMER_WIDTH-1:0] ch_count [CHANNELS];
	logic ch_pin_out [CHANNELS];
	logic ch_pin_oe [CHANNELS];
	logic ch_pin_event [CHANNELS];
	logic ch_underflow [CHANNELS];

	////////////////////////////////////////////////////////////////////////////////

	if (TIMER_WIDTH < 2 || TIMER_WIDTH > DATA_W) begin : g_width_check
		$error("TIMER_WIDTH must lie between 2 and the data bus width");
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			timer_pair_mode_reg <= MODE_RESET; // R11
		end else if (i_wr && i_addr == ADDR_MODE) begin
			timer_pair_mode_reg <= i_wdata;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_mask <= IRQ_MASK_RESET;
		end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
			irq_mask <= i_wdata[IRQ_BITS-1:0];
		end
	end

	assign irq_clear = (i_wr && i_addr == ADDR_IRQ_STATUS) ? i_wdata[IRQ_BITS-1:0] : '0;

	// A new event in the clearing cycle stays set.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_status <= IRQ_STATUS_RESET;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
		end
	end

	assign o_irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_rdata = '0;
		case (i_addr)
			ADDR_MODE: next_rdata = timer_pair_mode_reg;
			ADDR_TIMER_X: next_rdata = DATA_W'(ch_count[0]);
			ADDR_TIMER_Y: next_rdata = DATA_W'(ch_count[1]);
			ADDR_IRQ_STATUS: next_rdata = DATA_W'(irq_status);
			ADDR_IRQ_MASK: next_rdata = DATA_W'(irq_mask);
			default: next_rdata = '0;
		endcase
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= RDATA_RESET;
		end else if (i_rd) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= RDATA_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign ch_pin_in[0] = i_counter_pin_x;
	assign ch_pin_in[1] = i_counter_pin_y;
	assign ch_load[0] = i_wr && i_addr == ADDR_TIMER_X;
	assign ch_load[1] = i_wr && i_addr == ADDR_TIMER_Y;

	for (genvar c = 0; c < CHANNELS; c++) begin : g_channel
		localparam int BASE = c * FIELD_STRIDE;

		assign ch_mode[c] = timer_pair_mode_reg[BASE+MODE_LSB +: 2]; // R01 R02
		assign ch_stop[c] = timer_pair_mode_reg[BASE+STOP_BIT]; // R03 R04
		assign ch_edge[c] = timer_pair_mode_reg[BASE+EDGE_BIT]; // R05
		assign irq_events[IRQ_PIN_LSB+c] = ch_pin_event[c];
		assign irq_events[IRQ_UNDERFLOW_LSB+c] = ch_underflow[c];

		dtmc_channel #(
			.WIDTH(TIMER_WIDTH)
		) u_channel (
			.i_ref_clk(i_ref_clk),
			.i_reset_n(i_reset_n),
			.i_mode(ch_mode[c]),
			.i_stop(ch_stop[c]),
			.i_edge_sel(ch_edge[c]),
			.i_load(ch_load[c]),
			.i_load_value(i_wdata[TIMER_WIDTH-1:0]),
			.i_pin(ch_pin_in[c]),
			.o_count(ch_count[c]),
			.o_pin(ch_pin_out[c]),
			.o_pin_oe(ch_pin_oe[c]),
			.o_pin_event(ch_pin_event[c]),
			.o_underflow(ch_underflow[c])
		);
	end

	assign o_counter_pin_x = ch_pin_out[0];
	assign o_counter_pin_x_oe = ch_pin_oe[0];
	assign o_counter_pin_y = ch_pin_out[1];
	assign o_counter_pin_y_oe = ch_pin_oe[1];

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge i_ref_clk);
	endclocking

	default disable iff (!i_reset_n);

	mode_x_drive_a: assert property ( // R01
		o_counter_pin_x_oe == (timer_pair_mode_reg[1:0] == MODE_PULSE)
	) else $error("Timer X pin drive does not match its mode field.");

	mode_y_drive_a: assert property ( // R02
		o_counter_pin_y_oe == (timer_pair_mode_reg[5:4] == MODE_PULSE)
	) else $error("Timer Y pin drive does not match its mode field.");

	stop_x_hold_a: assert property ( // R03
		timer_pair_mode_reg[3] && !ch_load[0] |=> $stable(ch_count[0])
	) else $error("Timer X count moved while stopped.");

	stop_y_hold_a: assert property ( // R04
		timer_pair_mode_reg[7] && !ch_load[1] |=> $stable(ch_count[1])
	) else $error("Timer Y count moved while stopped.");

	edge_y_select_a: assert property ( // R05
		timer_pair_mode_reg[5:4] == MODE_EVENT && !timer_pair_mode_reg[7]
		&& !ch_load[1] && timer_pair_mode_reg[6] && $rose(i_counter_pin_y)
		|=> $stable(ch_count[1])
	) else $error("Timer Y counted a rising edge with falling edge selected.");

	timer_count_a: assert property ( // R06
		timer_pair_mode_reg[1:0] == MODE_TIMER && !timer_pair_mode_reg[3]
		&& !ch_load[0] && ch_count[0] != '0
		|=> ch_count[0] == $past(ch_count[0]) - 1'b1
	) else $error("Timer X did not count one per clock in timer mode.");

	pin_request_x_a: assert property ( // R07
		(!timer_pair_mode_reg[2] && $fell(i_counter_pin_x))
		or (timer_pair_mode_reg[2] && $rose(i_counter_pin_x))
		|=> irq_status[IRQ_PIN_LSB]
	) else $error("Selected edge on pin X raised no request.");

	no_wrong_edge_a: assert property ( // R07
		!timer_pair_mode_reg[2] && $rose(i_counter_pin_x)
		&& !irq_status[IRQ_PIN_LSB]
		|=> !irq_status[IRQ_PIN_LSB]
	) else $error("Unselected edge on pin X raised a request.");

	pulse_start_a: assert property ( // R08
		timer_pair_mode_reg[1:0] != MODE_PULSE ##1
		timer_pair_mode_reg[1:0] == MODE_PULSE
		|-> o_counter_pin_x == !timer_pair_mode_reg[2] && o_counter_pin_x_oe
	) else $error("Pulse output on pin X began at the wrong level.");

	event_count_a: assert property ( // R09
		timer_pair_mode_reg[1:0] == MODE_EVENT && !timer_pair_mode_reg[3]
		&& !ch_load[0] && ch_count[0] != '0
		&& ((!timer_pair_mode_reg[2] && $rose(i_counter_pin_x))
		|| (timer_pair_mode_reg[2] && $fell(i_counter_pin_x)))
		|=> ch_count[0] == $past(ch_count[0]) - 1'b1
	) else $error("Timer X missed a selected edge in event mode.");

	width_hold_a: assert property ( // R10
		timer_pair_mode_reg[1:0] == MODE_WIDTH && !ch_load[0]
		&& i_counter_pin_x == timer_pair_mode_reg[2]
		|=> $stable(ch_count[0])
	) else $error("Timer X counted outside the measured level.");

	reset_mode_a: assert property ( // R11
		!$past(i_reset_n) |-> timer_pair_mode_reg == MODE_RESET && !o_irq
	) else $error("Mode register not zero after reset.");

	read_mode_a: assert property ( // R11
		i_rd && i_addr == ADDR_MODE |=> o_rdata == $past(timer_pair_mode_reg)
		##1 o_rdata == RDATA_RESET || $past(i_rd)
	) else $error("Mode register read returned the wrong value.");

	////////////////////////////////////////////////////////////////////////////////

	// Register and stop checks, timer Y checks that mirror those of timer X, then event skip and width checks for both timers.

	mode_write_a: assert property ( // R01 R02
		i_wr && i_addr == ADDR_MODE |=> timer_pair_mode_reg == $past(i_wdata)
	) else $error("Mode register did not take the written byte.");

	mode_keep_a: assert property ( // R01 R02
		!(i_wr && i_addr == ADDR_MODE) |=> $stable(timer_pair_mode_reg)
	) else $error("Mode register changed without a write.");

	reset_pins_a: assert property ( // R11
		!$past(i_reset_n) |-> !o_counter_pin_x_oe && !o_counter_pin_y_oe
	) else $error("A counter pin was driven right after reset.");

	stop_x_quiet_a: assert property ( // R03
		timer_pair_mode_reg[3] |-> !ch_underflow[0]
	) else $error("Timer X underflowed while stopped.");

	stop_y_quiet_a: assert property ( // R04
		timer_pair_mode_reg[7] |-> !ch_underflow[1]
	) else $error("Timer Y underflowed while stopped.");

	timer_count_y_a: assert property ( // R06
		timer_pair_mode_reg[5:4] == MODE_TIMER && !timer_pair_mode_reg[7]
		&& !ch_load[1] && ch_count[1] != '0
		|=> ch_count[1] == $past(ch_count[1]) - 1'b1
	) else $error("Timer Y did not count one per clock in timer mode.");

	pin_request_y_a: assert property ( // R07
		(!timer_pair_mode_reg[6] && $fell(i_counter_pin_y))
		or (timer_pair_mode_reg[6] && $rose(i_counter_pin_y))
		|=> irq_status[IRQ_PIN_LSB+1]
	) else $error("Selected edge on pin Y raised no request.");

	no_wrong_edge_y_a: assert property ( // R07
		!timer_pair_mode_reg[6] && $rose(i_counter_pin_y)
		&& !irq_status[IRQ_PIN_LSB+1]
		|=> !irq_status[IRQ_PIN_LSB+1]
	) else $error("Unselected edge on pin Y raised a request.");

	pulse_start_y_a: assert property ( // R08
		timer_pair_mode_reg[5:4] != MODE_PULSE ##1
		timer_pair_mode_reg[5:4] == MODE_PULSE
		|-> o_counter_pin_y == !timer_pair_mode_reg[6] && o_counter_pin_y_oe
	) else $error("Pulse output on pin Y began at the wrong level.");

	event_count_y_a: assert property ( // R09
		timer_pair_mode_reg[5:4] == MODE_EVENT && !timer_pair_mode_reg[7]
		&& !ch_load[1] && ch_count[1] != '0
		&& ((!timer_pair_mode_reg[6] && $rose(i_counter_pin_y))
		|| (timer_pair_mode_reg[6] && $fell(i_counter_pin_y)))
		|=> ch_count[1] == $past(ch_count[1]) - 1'b1
	) else $error("Timer Y missed a selected edge in event mode.");

	event_skip_x_a: assert property ( // R09
		timer_pair_mode_reg[1:0] == MODE_EVENT && !ch_load[0]
		&& ((!timer_pair_mode_reg[2] && $fell(i_counter_pin_x))
		|| (timer_pair_mode_reg[2] && $rose(i_counter_pin_x)))
		|=> $stable(ch_count[0])
	) else $error("Timer X counted an unselected edge in event mode.");

	event_skip_y_a: assert property ( // R09
		timer_pair_mode_reg[5:4] == MODE_EVENT && !ch_load[1]
		&& ((!timer_pair_mode_reg[6] && $fell(i_counter_pin_y))
		|| (timer_pair_mode_reg[6] && $rose(i_counter_pin_y)))
		|=> $stable(ch_count[1])
	) else $error("Timer Y counted an unselected edge in event mode.");

	width_count_x_a: assert property ( // R10
		timer_pair_mode_reg[1:0] == MODE_WIDTH && !timer_pair_mode_reg[3] && !ch_load[0]
		&& i_counter_pin_x != timer_pair_mode_reg[2] && ch_count[0] != '0
		|=> ch_count[0] == $past(ch_count[0]) - 1'b1
	) else $error("Timer X did not count during the measured level.");

	width_count_y_a: assert property ( // R10
		timer_pair_mode_reg[5:4] == MODE_WIDTH && !timer_pair_mode_reg[7] && !ch_load[1]
		&& i_counter_pin_y != timer_pair_mode_reg[6] && ch_count[1] != '0
		|=> ch_count[1] == $past(ch_count[1]) - 1'b1
	) else $error("Timer Y did not count during the measured level.");

	width_hold_y_a: assert property ( // R10
		timer_pair_mode_reg[5:4] == MODE_WIDTH && !ch_load[1]
		&& i_counter_pin_y == timer_pair_mode_reg[6]
		|=> $stable(ch_count[1])
	) else $error("Timer Y counted outside the measured level.");

	pulse_toggle_c: cover property (
		o_counter_pin_x_oe && ch_underflow[0] ##1 $changed(o_counter_pin_x)
	);

	event_count_c: cover property (
		timer_pair_mode_reg[5:4] == MODE_EVENT && ch_underflow[1]
	);

	width_measure_c: cover property (
		timer_pair_mode_reg[1:0] == MODE_WIDTH && !timer_pair_mode_reg[2]
		&& i_counter_pin_x [*4] ##1 !i_counter_pin_x
	);

	irq_clear_c: cover property (
		o_irq ##1 (i_wr && i_addr == ADDR_IRQ_STATUS) ##1 !o_irq
	);

	pulse_start_y_c: cover property (
		timer_pair_mode_reg[5:4] != MODE_PULSE ##1 timer_pair_mode_reg[5:4] == MODE_PULSE
	);

endmodule

`default_nettype wire

// ==== verification/dtmc_pin_model.sv ====
`timescale 1ns/10ps
`default_nettype none

// Counter pin seen from outside: the device wins while it drives the pin.
module dtmc_pin_model (
	input wire logic i_level,
	input wire logic i_dev_out,
	input wire logic i_dev_oe,
	output logic o_line
);
	assign o_line = i_dev_oe ? i_dev_out : i_level;
endmodule

`default_nettype wire

// ==== verification/tb_dual_timer_mode_control.sv ====
`timescale 1ns/10ps
`default_nettype none

module tb_dual_timer_mode_control;
	import dtmc_pkg::*;
	logic i_ref_clk, i_reset_n, wr, rd, irq;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata, rdata, v, m;
	logic [1:0] drv;
	wire [1:0] line, pout, poe;
	int failures = 0;
	int total_checks = 0;
	dtmc_top dut_u (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
		.i_counter_pin_x(line[0]), .o_counter_pin_x(pout[0]), .o_counter_pin_x_oe(poe[0]),
		.i_counter_pin_y(line[1]), .o_counter_pin_y(pout[1]), .o_counter_pin_y_oe(poe[1]),
		.o_irq(irq));
	dtmc_pin_model pin_x (.i_level(drv[0]), .i_dev_out(pout[0]), .i_dev_oe(poe[0]),
		.o_line(line[0]));
	dtmc_pin_model pin_y (.i_level(drv[1]), .i_dev_out(pout[1]), .i_dev_oe(poe[1]),
		.o_line(line[1]));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_ref_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic pin(input int ch, input logic lv);
		@(posedge i_ref_clk);
		drv[ch] <= lv;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_modes;
		rd_reg(ADDR_MODE, v);
		chk("mode_reset", v, 8'h00);
		chk("oe_reset", {6'h00, poe}, 8'h00);
		for (int i = 0; i < 16; i++) begin
			m = {i[3:0], ~i[3:0]};
			wr_reg(ADDR_MODE, m);
			rd_reg(ADDR_MODE, v);
			chk("mode_rb", v, m);
			chk("oe", {6'h00, poe}, {6'h00, m[5:4] == 2'h1, m[1:0] == 2'h1});
		end
		wr_reg(8'h40, 8'hff);
		rd_reg(8'h40, v);
		chk("unmapped", v, 8'h00);
	endtask
	task automatic t_stop;
		wr_reg(ADDR_MODE, 8'h88);
		wr_reg(ADDR_TIMER_X, 8'h05);
		wr_reg(ADDR_TIMER_Y, 8'h09);
		tick(4);
		rd_reg(ADDR_TIMER_X, v);
		chk("x_held", v, 8'h05);
		wr_reg(ADDR_MODE, 8'h80);
		tick(3);
		rd_reg(ADDR_TIMER_X, v);
		chk("x_runs", v, 8'h01);
		rd_reg(ADDR_TIMER_Y, v);
		chk("y_held", v, 8'h09);
	endtask
	task automatic t_pin_irq;
		logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h3};
		wr_reg(ADDR_IRQ_MASK, 8'h03);
		for (int ch = 0; ch < 2; ch++) for (int k = 0; k < 3; k++) for (int e = 0; e < 2; e++) begin
			m = {4'h0, 1'b0, e[0], modes[k]} << (4 * ch);
			wr_reg(ADDR_MODE, m);
			pin(ch, e[0]);
			tick(2);
			wr_reg(ADDR_IRQ_STATUS, 8'hff);
			pin(ch, ~e[0]);
			tick(3);
			rd_reg(ADDR_IRQ_STATUS, v);
			chk("no_req", v & 8'h03, 8'h00);
			pin(ch, e[0]);
			tick(3);
			rd_reg(ADDR_IRQ_STATUS, v);
			chk("req", v & 8'h03, 8'h01 << ch);
			chk("irq_on", {7'h00, irq}, 8'h01);
			wr_reg(ADDR_IRQ_STATUS, 8'hff);
			#1;
			chk("irq_off", {7'h00, irq}, 8'h00);
		end
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		pin(0, 1'b1);
		pin(0, 1'b0);
		tick(3);
		chk("irq_masked", {7'h00, irq}, 8'h00);
	endtask
	task automatic t_count(input logic [1:0] md, input int steps, input logic [7:0] exp);
		for (int ch = 0; ch < 2; ch++) for (int e = 0; e < 2; e++) begin
			wr_reg(ADDR_MODE, {4'h0, 1'b0, e[0], md} << (4 * ch));
			pin(ch, e[0]);
			tick(2);
			wr_reg(ADDR_TIMER_X + ch[7:0], 8'h0a);
			pin(ch, ~e[0]);
			tick(steps - 1);
			pin(ch, e[0]);
			tick(3);
			rd_reg(ADDR_TIMER_X + ch[7:0], v);
			chk("count", v, exp);
		end
	endtask
	task automatic t_pulse;
		for (int ch = 0; ch < 2; ch++) for (int e = 0; e < 2; e++) begin
			wr_reg(ADDR_MODE, {4'h0, 1'b1, e[0], 2'h1} << (4 * ch));
			tick(2);
			chk("pulse_start", {7'h00, pout[ch]}, {7'h00, ~e[0]});
			chk("pulse_oe", {7'h00, poe[ch]}, 8'h01);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_ref_clk = 1'b0;
		forever #4 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		#500000;
		failures++;
		final_report;
	end
	initial begin
		i_reset_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = '0;
		wdata = '0;
		drv = 2'h0;
		repeat (4) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		tick(1);
		t_modes;
		t_stop;
		t_pin_irq;
		// One count edge in event mode, three measured cycles in width mode.
		t_count(2'h2, 1, 8'h09);
		t_count(2'h3, 3, 8'h07);
		t_pulse;
		final_report;
	end
endmodule

`default_nettype wire
